// *** tb/core_event_model.sv ***
// Model of the core event controller pending bits.
// Assumes gp inputs are levels on clk; lat of 3 or more cycles.
module core_event_model
   import irq_router_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic [NUM_GP-1:0] gpInput,
   input logic [7:0] lat,
   output logic [NUM_GP-1:0] corePending
);
   // ------------
   // Pending
   // ------------
   timeunit 1ns;
   timeprecision 1ps;
   logic [NUM_GP-1:0] prev;
   int cnt [NUM_GP];
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= '0;
         corePending <= '0;
         for (int g = 0; g < NUM_GP; g++) cnt[g] <= 0;
      end else begin
         prev <= gpInput;
         for (int g = 0; g < NUM_GP; g++) begin
            if (gpInput[g] && !prev[g]) cnt[g] <= 1;
            else if (cnt[g] != 0) cnt[g] <= cnt[g] + 1;
            if (cnt[g] == lat) corePending[g] <= 1'b1;
            if (cnt[g] == lat + 4) begin
               corePending[g] <= 1'b0;
               cnt[g] <= 0;
            end
         end
      end
   end
endmodule

// *** tb/system_irq_router_sva.sv ***
// Port-level assertions for the system interrupt router.
// Assumes hready is driven from hreadyout by the single master.
module system_irq_router_sva
   import irq_router_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   input logic [31:0] hrdata,
   input logic [NUM_SRC-1:0] srcReq,
   input logic [NUM_EXT_DMA-1:0] extDmaReq,
   input logic [NUM_GP-1:0] corePending,
   input logic [NUM_GP-1:0] gpInput,
   input core_level_t activeLevel,
   input logic wakeReq,
   input logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // Checks
   // ------------
   localparam logic [NUM_SRC-1:0] RSVD = 96'h003f0400_04000000_00000000;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   assign take = hsel && htrans[1] && hready;
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_ONE_WAIT: assert property (!hreadyout |=> hreadyout)
      else $error("wait state too long");
   AST_RD_HOLD: assert property ($changed(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a read");
   AST_NO_REQ: assert property ((srcReq & ~RSVD) == '0 && extDmaReq == '0
      |=> gpInput == '0)
      else $error("gp input without request");
   AST_LEVEL: assert property (activeLevel >= LVL_GP7 && activeLevel != LVL_GP14)
      else $error("level outside peripheral range");
   AST_LEVEL_IDLE: assert property (gpInput == '0 [*2] |-> activeLevel == LVL_GP15)
      else $error("level not idle");
   AST_WAKE: assert property (wakeReq |-> $past(|srcReq || |extDmaReq))
      else $error("wake without request");
   COV_READ: cover property (take && !hwrite);
   COV_GP: cover property (|gpInput);
   COV_IRQ: cover property (irq);
   COV_WAKE: cover property (wakeReq);
endmodule

bind system_irq_router system_irq_router_sva chk (.clk, .rst, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
   .srcReq, .extDmaReq, .corePending, .gpInput, .activeLevel, .wakeReq,
   .irq);

// *** tb/system_irq_router_tb.sv ***
// Self-checking bench for the system interrupt router.
// Assumes one AHB-Lite master and the core event model.
module system_irq_router_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_router_pkg::*;
   // ------------
   // Bench
   // ------------
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, q, hrdata;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [NUM_SRC-1:0] srcReq = '0;
   logic [NUM_EXT_DMA-1:0] extDmaReq = '0;
   logic [7:0] lat = 8'h03;
   logic hready, hreadyout, hresp, wakeReq, irq;
   logic [NUM_GP-1:0] corePending, gpInput;
   core_level_t activeLevel;
   int n_mismatch = 0, n_checks = 0;
   always #5 clk = ~clk;
   assign hready = hreadyout;
   system_irq_router dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .srcReq,
      .extDmaReq, .corePending, .gpInput, .activeLevel, .wakeReq, .irq);
   core_event_model pm (.clk, .rst, .gpInput, .lat, .corePending);
   task test_done;
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(string w, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", w, e, s);
      end
   endtask
   task waitRdy;
      int n;
      logic r;
      n = 0;
      do begin
         @(negedge clk);
         r = hreadyout;
         q = hrdata;
         n++;
         if (n > 20) begin
            n_mismatch++;
            test_done;
         end
         @(posedge clk);
      end while (r !== 1'b1);
   endtask
   task bus(logic w, logic [7:0] a, logic [31:0] d, logic far = 1'b0);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {23'h0, far, a};
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy;
   endtask
   task t_defaults;
      int hi[17] = '{6,8,12,15,18,20,23,32,38,44,48,50,53,63,69,93,95};
      int cd[17] = '{0,1,2,3,4,5,6,0,2,3,4,6,4,0,1,4,5};
      logic [31:0] e;
      int r;
      for (int k = 0; k < 12; k++) begin
         for (int j = 0; j < 8; j++) begin
            r = 0;
            while (8 * k + j > hi[r]) r++;
            e[4*j+:4] = 4'(cd[r]);
         end
         bus(0, ASSIGN_OFS + 8'(4 * k), 0);
         chk("assign word", e, q);
      end
      hsize <= 3'h0;
      bus(0, ASSIGN_OFS, 0);
      chk("byte read", 0, q);
      hsize <= 3'h2;
      bus(0, MASK_OFS, 0, 1'b1);
      chk("far read", 0, q);
   endtask
   task t_route;
      bus(1, MASK_OFS + 8'h04, 32'h8c00_0000);
      srcReq[59] <= 1'b1;
      for (int c = 0; c <= 7; c++) begin
         bus(1, ASSIGN_OFS + 8'h1c, {8{4'(c)}});
         bus(0, ASSIGN_OFS + 8'h1c, 0);
         chk("assign readback", {8{4'(c)}}, q);
         @(negedge clk);
         chk("gp input", c < 7 ? 32'(1 << c) : 0, 32'(gpInput));
         chk("level", c < 7 ? 7 + c : 15, 32'(activeLevel));
         @(posedge clk);
      end
      srcReq[59] <= 1'b0;
      bus(1, ASSIGN_OFS + 8'h1c, 0);
   endtask
   task t_share;
      bus(1, MASK_OFS, 32'h1);
      bus(1, MASK_OFS, '1, 1'b1);
      srcReq[1] <= 1'b1;
      srcReq[58] <= 1'b1;
      bus(0, STAT_OFS, 0);
      chk("status word", 32'h2, q);
      chk("gp masked", 0, 32'(gpInput));
      srcReq <= '0;
      extDmaReq <= 4'h8;
      bus(0, STAT_OFS + 8'h04, 0);
      chk("status shared", 32'h8000_0000, q);
      chk("gp shared", 32'h1, 32'(gpInput));
      extDmaReq <= '0;
   endtask
   task t_events;
      int n;
      bus(1, EVST_OFS, 32'h3fff);
      bus(1, EVMSK_OFS, 32'h1);
      bus(1, WAKE_OFS, 32'h2);
      lat <= 8'h09;
      srcReq[1:0] <= 2'b11;
      @(posedge clk);
      @(negedge clk);
      chk("irq raised", 1, irq);
      chk("wake", 1, wakeReq);
      n = 0;
      while (corePending[0] !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      if (n >= 30) begin
         chk("ack wait", 1, 0);
         test_done;
      end
      @(posedge clk);
      bus(0, EVST_OFS, 0);
      chk("event status", 32'h81, q);
      bus(1, EVST_OFS, 32'h1);
      bus(1, WAKE_OFS, 32'h0);
      bus(0, EVST_OFS, 0);
      chk("event cleared", 32'h80, q);
      chk("irq cleared", 0, irq);
      chk("wake off", 0, wakeReq);
      srcReq <= '0;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_route;
      t_share;
      t_events;
      test_done;
   end
endmodule

// *** verilog/ahb_reg_port.sv ***
// AHB-Lite slave that turns bus transfers into register accesses.
// Assumes whole-word single transfers; reads take one wait state.
module ahb_reg_port
   import irq_router_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output reg_access_t access,
   input wire logic [31:0] rdData
);

   bus_state_vec_t q;
   bus_state_vec_t d;
   logic take;

   // ----------------------------------------------------------------
   // Address and data phase tracking
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      take = hsel && htrans[1] && hready;
      hreadyout = 1'b1;
      access.wr = 1'b0;
      access.addr = q.addr;
      access.wdata = hwdata;
      case (q.st)
         BUS_WRITE: access.wr = q.hit;
         BUS_READ: begin
            hreadyout = 1'b0;
            d.rdata = q.hit ? rdData : 32'h0;
            d.st = BUS_RDONE;
         end
         default: ;
      endcase
      if (q.st != BUS_READ) begin
         d.st = BUS_IDLE;
         if (take) begin
            d.st = hwrite ? BUS_WRITE : BUS_READ;
            d.hit = haddr[31:ADDR_W] == '0 && hsize == 3'h2;
            d.addr = {haddr[ADDR_W-1:2], 2'b00};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{BUS_IDLE, 1'b0, 8'h0, 32'h0};
      end else begin
         q <= d;
      end
   end

   assign hresp = 1'b0;
   assign hrdata = q.rdata;

endmodule

// *** verilog/irq_router_pkg.sv ***
// Constants, register map and carrier types of the interrupt router.
// Assumes one 100 MHz system clock and an AHB-Lite register bus.
package irq_router_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 96;
   localparam int NUM_GP = 7;
   localparam int CODE_W = 4;
   localparam int FIELDS_PER_WORD = 8;
   localparam int NUM_MASK_WORDS = 3;
   localparam int NUM_ASSIGN_WORDS = 12;
   localparam int NUM_EXT_DMA = 4;
   localparam int NUM_EV = 14;
   localparam int ADDR_W = 8;
   localparam int SHARED_DMA_ID = 63;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MASK_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] WAKE_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] EVST_OFS = 8'h24;
   localparam logic [ADDR_W-1:0] EVMSK_OFS = 8'h28;
   localparam logic [ADDR_W-1:0] LEVEL_OFS = 8'h2c;
   localparam logic [ADDR_W-1:0] ASSIGN_OFS = 8'h40;
   localparam logic [NUM_SRC-1:0] MASK_RST = 96'h0;
   localparam logic [NUM_SRC-1:0] WAKE_RST = 96'h0;
   localparam logic [NUM_EV-1:0] EVMSK_RST = 14'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      LVL_EMU = 4'h0, LVL_RESET = 4'h1, LVL_NMI = 4'h2, LVL_EXC = 4'h3,
      LVL_RSVD = 4'h4, LVL_HWERR = 4'h5, LVL_TIMER = 4'h6,
      LVL_GP7 = 4'h7, LVL_GP8 = 4'h8, LVL_GP9 = 4'h9, LVL_GP10 = 4'ha,
      LVL_GP11 = 4'hb, LVL_GP12 = 4'hc, LVL_GP13 = 4'hd,
      LVL_GP14 = 4'he, LVL_GP15 = 4'hf
   } core_level_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00, BUS_WRITE = 2'b01, BUS_READ = 2'b10,
      BUS_RDONE = 2'b11
   } bus_state_t;

   typedef logic [NUM_SRC-1:0][CODE_W-1:0] assign_vec_t;

   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } reg_access_t;

   typedef struct packed {
      bus_state_t st;
      logic hit;
      logic [ADDR_W-1:0] addr;
      logic [31:0] rdata;
   } bus_state_vec_t;

   typedef struct packed {
      logic [NUM_SRC-1:0] mask;
      logic [NUM_SRC-1:0] wake;
      assign_vec_t codes;
      logic [NUM_GP-1:0] gp;
      logic [NUM_GP-1:0] sent;
      logic [NUM_EV-1:0] evStat;
      logic [NUM_EV-1:0] evMask;
      logic irq;
      logic wakeUp;
      core_level_t level;
   } router_state_t;

   // ----------------------------------------------------------------
   // Source decoding
   // ----------------------------------------------------------------
   function automatic logic isReserved(input int id);
      return id == 58 || id == 74 || (id >= 80 && id <= 85);
   endfunction

   function automatic logic [CODE_W-1:0] defaultCode(input int id);
      if (id <= 6) return 4'h0;
      else if (id <= 8) return 4'h1;
      else if (id <= 12) return 4'h2;
      else if (id <= 15) return 4'h3;
      else if (id <= 18) return 4'h4;
      else if (id <= 20) return 4'h5;
      else if (id <= 23) return 4'h6;
      else if (id <= 32) return 4'h0;
      else if (id <= 38) return 4'h2;
      else if (id <= 44) return 4'h3;
      else if (id <= 48) return 4'h4;
      else if (id <= 50) return 4'h6;
      else if (id <= 53) return 4'h4;
      else if (id <= 63) return 4'h0;
      else if (id <= 69) return 4'h1;
      else if (id <= 93) return 4'h4;
      else return 4'h5;
   endfunction

   function automatic assign_vec_t defaultCodes();
      assign_vec_t v;
      for (int i = 0; i < NUM_SRC; i++) begin
         v[i] = defaultCode(i);
      end
      return v;
   endfunction

   localparam assign_vec_t CODES_RST = defaultCodes();

   function automatic logic [ADDR_W-1:0] wordAddr(
      input logic [ADDR_W-1:0] base, input int idx);
      return base + ADDR_W'(idx * 4);
   endfunction

endpackage

// *** verilog/source_router.sv ***
// Combines routed requests onto the core's general-purpose inputs.
// Assumes requests are already masked and reserved IDs cleared.
module source_router
   import irq_router_pkg::*;
(
   input wire logic [NUM_SRC-1:0] req,
   input wire assign_vec_t codes,
   output logic [NUM_GP-1:0] gp
);

   logic [NUM_GP-1:0][NUM_SRC-1:0] hit;

   // ----------------------------------------------------------------
   // Per-input OR of assigned sources
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_GP; g++) begin : gpLoop
      for (genvar s = 0; s < NUM_SRC; s++) begin : srcLoop
         // One code selects one input only
         assign hit[g][s] = req[s] && codes[s] == CODE_W'(g);
      end
      assign gp[g] = |hit[g];
   end

endmodule

// *** verilog/system_irq_router.sv ***
// Top of the system interrupt router: registers, routing, events.
// Assumes peripheral requests and core pending bits share clk.
//
// Overview of operation
// - Each source reaches at most one selected core general-purpose input; codes 7 to 15 reach none.
// - Core events rank 0 highest to 15; peripheral inputs are 7 to 13.
// - Software writes to assignment registers change each source's input.
// - Code 0 selects input 7, up to code 6 selecting input 13.
// - Watchdog 23 and memory DMA 21, 22, 49, 50 reset to code 6.
// - Media transceiver sources 51 to 53 reset to code 4.
// - Pixel compositor source 59 resets to code 0.
// - Both external DMA channels' block and overflow requests share ID 63.
// - Source 38 carries DMA channel 14 and resets to code 2.
// - A set mask bit passes a source; a clear bit blocks it.
// - Status bit reads one while the source asserts its request.
// - An enabled wakeup bit lets a source wake the idled core.
// - Core pending indication acknowledges the request on that input.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
module system_irq_router
   import irq_router_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_SRC-1:0] srcReq,
   input wire logic [NUM_EXT_DMA-1:0] extDmaReq,
   input wire logic [NUM_GP-1:0] corePending,
   output logic [NUM_GP-1:0] gpInput,
   output core_level_t activeLevel,
   output logic wakeReq,
   output logic irq
);

   router_state_t q;
   router_state_t d;
   reg_access_t access;
   logic [31:0] rdData;
   logic [NUM_SRC-1:0] rawReq;
   logic [NUM_SRC-1:0] passReq;
   logic [NUM_GP-1:0] routed;
   logic [NUM_GP-1:0] rise;
   logic [NUM_GP-1:0] ack;
   logic [NUM_EV-1:0] evSet;
   logic [NUM_EV-1:0] evClr;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   ahb_reg_port busPort (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .access(access),
      .rdData(rdData)
   );

   // ----------------------------------------------------------------
   // Source conditioning
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         rawReq[i] = srcReq[i] && !isReserved(i);
      end
      // Four external DMA requests on one line
      rawReq[SHARED_DMA_ID] = srcReq[SHARED_DMA_ID] || |extDmaReq;
      passReq = rawReq & q.mask;
   end

   source_router router (
      .req(passReq),
      .codes(q.codes),
      .gp(routed)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   function automatic logic [31:0] sliceWord(
      input logic [NUM_SRC-1:0] v, input int w);
      return v[w*32 +: 32];
   endfunction

   always_comb begin
      rdData = 32'h0;
      for (int w = 0; w < NUM_MASK_WORDS; w++) begin
         if (access.addr == wordAddr(MASK_OFS, w)) begin
            rdData = sliceWord(q.mask, w);
         end
         if (access.addr == wordAddr(STAT_OFS, w)) begin
            rdData = sliceWord(rawReq, w);
         end
         if (access.addr == wordAddr(WAKE_OFS, w)) begin
            rdData = sliceWord(q.wake, w);
         end
      end
      for (int k = 0; k < NUM_ASSIGN_WORDS; k++) begin
         if (access.addr == wordAddr(ASSIGN_OFS, k)) begin
            rdData = q.codes[k*FIELDS_PER_WORD +: FIELDS_PER_WORD];
         end
      end
      if (access.addr == EVST_OFS) begin
         rdData = {18'h0, q.evStat};
      end
      if (access.addr == EVMSK_OFS) begin
         rdData = {18'h0, q.evMask};
      end
      if (access.addr == LEVEL_OFS) begin
         rdData = {28'h0, q.level};
      end
   end

   // ----------------------------------------------------------------
   // Events: input raised, and input acknowledged by the core
   // ----------------------------------------------------------------
   always_comb begin
      rise = routed & ~q.gp;
      ack = corePending & q.sent;
      evSet = {ack, rise};
      evClr = '0;
      if (access.wr && access.addr == EVST_OFS) begin
         evClr = access.wdata[NUM_EV-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      if (access.wr) begin
         for (int w = 0; w < NUM_MASK_WORDS; w++) begin
            if (access.addr == wordAddr(MASK_OFS, w)) begin
               d.mask[w*32 +: 32] = access.wdata;
            end
            if (access.addr == wordAddr(WAKE_OFS, w)) begin
               d.wake[w*32 +: 32] = access.wdata;
            end
         end
         for (int k = 0; k < NUM_ASSIGN_WORDS; k++) begin
            if (access.addr == wordAddr(ASSIGN_OFS, k)) begin
               // Whole word holds eight source fields
               d.codes[k*FIELDS_PER_WORD +: FIELDS_PER_WORD] =
                  access.wdata;
            end
         end
         if (access.addr == EVMSK_OFS) begin
            d.evMask = access.wdata[NUM_EV-1:0];
         end
      end
      // Core inputs follow routed requests one cycle later
      d.gp = routed;
      // Delivery stays outstanding until the core takes it
      d.sent = (q.sent & ~corePending) | rise;
      // Sticky events, a new event beats a same-cycle clear
      d.evStat = (q.evStat & ~evClr) | evSet;
      d.irq = |(d.evStat & d.evMask);
      d.wakeUp = |(rawReq & q.wake);
      d.level = LVL_GP15;
      for (int g = NUM_GP - 1; g >= 0; g--) begin
         if (routed[g]) begin
            d.level = core_level_t'(LVL_GP7 + 4'(g));
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q.mask <= MASK_RST;
         q.wake <= WAKE_RST;
         q.codes <= CODES_RST;
         q.gp <= '0;
         q.sent <= '0;
         q.evStat <= '0;
         q.evMask <= EVMSK_RST;
         q.irq <= 1'b0;
         q.wakeUp <= 1'b0;
         q.level <= LVL_GP15;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign gpInput = q.gp;
   assign activeLevel = q.level;
   assign wakeReq = q.wakeUp;
   assign irq = q.irq;

endmodule
